/* bto_pkg.sv */
// Shared constants and types of the bridge ordering engine and its bus agents.
// Assumes both ends import this package whole.
package bto_pkg;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int SEQ_W = 8;
	localparam int DIR_DOWN = 0;
	localparam int DIR_UP = 1;
	localparam int PW_DEPTH_DEF = 4;
	localparam int DQ_DEPTH_DEF = 2;
	localparam int CQ_DEPTH_DEF = 2;
	localparam int AG_SLOTS_DEF = 2;
	localparam int AG_WORDS_DEF = 16;
	localparam logic [3:0] CMD_IO_RD = 4'h2;
	localparam logic [3:0] CMD_IO_WR = 4'h3;
	localparam logic [3:0] CMD_MEM_RD = 4'h6;
	localparam logic [3:0] CMD_MEM_WR = 4'h7;
	localparam logic [3:0] CMD_CFG_RD = 4'ha;
	localparam logic [3:0] CMD_CFG_WR = 4'hb;
	localparam logic [3:0] CMD_MEM_WRI = 4'hf;
	localparam logic [SEQ_W-1:0] SEQ_RST = 8'h00;
	localparam logic RR_RST = 1'b0;

	typedef struct packed {
		logic [3:0] cmd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic [3:0] be;
	} bto_txn_t;

	typedef enum logic [1:0] {
		BTO_M_IDLE = 2'b00,
		BTO_M_PW = 2'b01,
		BTO_M_DR = 2'b10
	} bto_mst_t;

	function automatic logic bto_is_posted(input logic [3:0] cmd);
		return cmd == CMD_MEM_WR || cmd == CMD_MEM_WRI;
	endfunction : bto_is_posted

	// True once the out counter has reached the tag, wrap-safe
	function automatic logic bto_seq_ok(input logic [SEQ_W-1:0] tag, input logic [SEQ_W-1:0] cnt);
		logic [SEQ_W-1:0] df;
		df = tag - cnt;
		return df == '0 || df[SEQ_W-1];
	endfunction : bto_seq_ok
endpackage : bto_pkg

/* bto_if.sv */
// Carrier between the bridge ordering engine and the bus agents.
// Index 0 is the downstream direction, index 1 upstream.
`timescale 1ns/1ns
interface bto_if import bto_pkg::*;;
	logic ini_valid [2];
	bto_txn_t ini_txn [2];
	logic ini_done [2];
	logic ini_retry [2];
	logic [DATA_W-1:0] ini_rdata [2];
	logic tgt_valid [2];
	bto_txn_t tgt_txn [2];
	logic tgt_ack [2];
	logic [DATA_W-1:0] tgt_rdata [2];

	modport bridge (
		input ini_valid, ini_txn, tgt_ack, tgt_rdata,
		output ini_done, ini_retry, ini_rdata, tgt_valid, tgt_txn
	);
	modport agent (
		output ini_valid, ini_txn, tgt_ack, tgt_rdata,
		input ini_done, ini_retry, ini_rdata, tgt_valid, tgt_txn
	);
endinterface : bto_if

/* bto_agent.sv */
// Bus agents on both sides: an initiator and a target for each direction.
// Assumes the bridge answers each request with one done or retry pulse.
`timescale 1ns/1ns
module bto_agent import bto_pkg::*; #(
	parameter int NSLOT = AG_SLOTS_DEF,
	parameter int WORDS = AG_WORDS_DEF
) (
	input wire logic clk,
	input wire logic rst,
	bto_if.agent bus,
	input wire logic [1:0] usr_valid,
	input bto_txn_t usr_txn [2],
	input wire logic [1:0] usr_inorder,
	output logic [1:0] usr_ready,
	output logic [1:0] cpl_valid,
	output logic [DATA_W-1:0] cpl_rdata [2],
	output logic [1:0] sync_ok
);
	localparam int SW = (NSLOT > 1) ? $clog2(NSLOT) : 1;
	localparam int MW = $clog2(WORDS);

	for (genvar d = 0; d < 2; d++) begin : g_dir
		bto_txn_t sl_q [NSLOT];
		bto_txn_t sl_d [NSLOT];
		logic [NSLOT-1:0] sv_q, sv_d;
		logic [SW-1:0] ptr_q, ptr_d;
		logic iv_q, iv_d, cv_q, cv_d, rdy_q, rdy_d, sok_q, sok_d, ack_q, ack_d;
		logic [DATA_W-1:0] cr_q, cr_d, trd_q, trd_d;
		logic [DATA_W-1:0] mem_q [WORDS];
		logic [DATA_W-1:0] mem_d [WORDS];

		always_comb begin
			logic found, has_free, dly, pst;
			int j;
			logic [SW-1:0] fr;
			logic [MW-1:0] wi;
			found = 1'b0;
			has_free = 1'b0;
			dly = 1'b0;
			pst = 1'b0;
			j = 0;
			fr = '0;
			wi = bus.tgt_txn[d].addr[MW+1:2];
			sl_d = sl_q;
			sv_d = sv_q;
			ptr_d = ptr_q;
			iv_d = iv_q;
			cv_d = 1'b0;
			cr_d = cr_q;
			sok_d = sok_q;
			mem_d = mem_q;
			ack_d = 1'b0;
			trd_d = trd_q;
			for (int i = NSLOT - 1; i >= 0; i--) begin
				if (!sv_q[i]) fr = SW'(i);
			end
			if (iv_q) begin
				if (bus.ini_done[d] || bus.ini_retry[d]) iv_d = 1'b0;
				if (bus.ini_done[d]) begin
					sv_d[ptr_q] = 1'b0;
					cv_d = 1'b1;
					cr_d = bus.ini_rdata[d];
					if (bto_is_posted(sl_q[ptr_q].cmd)) sok_d = 1'b0;
					else if (!sl_q[ptr_q].cmd[0]) sok_d = 1'b1;
				end
			end else begin
				// Round robin from the slot after the last one tried
				for (int k = 1; k <= NSLOT; k++) begin
					j = (int'(ptr_q) + k) % NSLOT;
					if (!found && sv_q[j]) begin
						found = 1'b1;
						ptr_d = SW'(j);
						iv_d = 1'b1;
					end
				end
			end
			if (usr_valid[d] && rdy_q) begin
				sv_d[fr] = 1'b1;
				sl_d[fr] = usr_txn[d];
			end
			for (int i = 0; i < NSLOT; i++) begin
				if (!sv_d[i]) has_free = 1'b1;
				if (sv_d[i] && bto_is_posted(sl_d[i].cmd)) pst = 1'b1;
				if (sv_d[i] && !bto_is_posted(sl_d[i].cmd)) dly = 1'b1;
			end
			// Pending posted write blocks new work so source order holds
			rdy_d = has_free && !pst && !(usr_inorder[d] && dly);
			// Target side never waits on own mastered work
			if (bus.tgt_valid[d] && !ack_q) begin
				ack_d = 1'b1;
				trd_d = mem_q[wi];
				if (bus.tgt_txn[d].cmd[0]) begin
					for (int b = 0; b < 4; b++) begin
						if (bus.tgt_txn[d].be[b]) mem_d[wi][8*b +: 8] = bus.tgt_txn[d].data[8*b +: 8];
					end
				end
			end
		end

		always_ff @(posedge clk) begin
			sl_q <= sl_d;
			mem_q <= mem_d;
			cr_q <= cr_d;
			trd_q <= trd_d;
			if (rst) begin
				sv_q <= '0;
				ptr_q <= '0;
				iv_q <= 1'b0;
				cv_q <= 1'b0;
				rdy_q <= 1'b0;
				sok_q <= 1'b1;
				ack_q <= 1'b0;
			end else begin
				sv_q <= sv_d;
				ptr_q <= ptr_d;
				iv_q <= iv_d;
				cv_q <= cv_d;
				rdy_q <= rdy_d;
				sok_q <= sok_d;
				ack_q <= ack_d;
			end
		end

		assign bus.ini_valid[d] = iv_q;
		assign bus.ini_txn[d] = sl_q[ptr_q];
		assign bus.tgt_ack[d] = ack_q;
		assign bus.tgt_rdata[d] = trd_q;
		assign usr_ready[d] = rdy_q;
		assign cpl_valid[d] = cv_q;
		assign cpl_rdata[d] = cr_q;
		assign sync_ok[d] = sok_q;
	end
endmodule : bto_agent

/* bto_bridge.sv */
// Ordering engine of a two-port bridge: queues and per-direction master arbiter.
// Assumes agents hold a request until answered and ack each target cycle once.
`timescale 1ns/1ns
module bto_bridge import bto_pkg::*; #(
	parameter int PW_DEPTH = PW_DEPTH_DEF,
	parameter int DQ_DEPTH = DQ_DEPTH_DEF,
	parameter int CQ_DEPTH = CQ_DEPTH_DEF
) (
	input wire logic clk,
	input wire logic rst,
	bto_if.bridge bus,
	output logic [1:0] dir_idle
);
	// Depths must be powers of two, counters double as pointers
	localparam int PW_AW = $clog2(PW_DEPTH);
	localparam int DQ_AW = $clog2(DQ_DEPTH);
	localparam int CQ_AW = $clog2(CQ_DEPTH);

	for (genvar d = 0; d < 2; d++) begin : g_dir
		localparam int O = 1 - d;
		bto_txn_t pw_mem_q [PW_DEPTH];
		bto_txn_t pw_mem_d [PW_DEPTH];
		bto_txn_t dq_mem_q [DQ_DEPTH];
		bto_txn_t dq_mem_d [DQ_DEPTH];
		logic [SEQ_W-1:0] dq_tag_q [DQ_DEPTH];
		logic [SEQ_W-1:0] dq_tag_d [DQ_DEPTH];
		bto_txn_t cq_mem_q [CQ_DEPTH];
		bto_txn_t cq_mem_d [CQ_DEPTH];
		logic [DATA_W-1:0] cq_rd_q [CQ_DEPTH];
		logic [DATA_W-1:0] cq_rd_d [CQ_DEPTH];
		logic [SEQ_W-1:0] cq_tag_q [CQ_DEPTH];
		logic [SEQ_W-1:0] cq_tag_d [CQ_DEPTH];
		logic [SEQ_W-1:0] pw_in_q, pw_in_d, pw_out_q, pw_out_d;
		logic [SEQ_W-1:0] dq_in_q, dq_in_d, dq_out_q, dq_out_d;
		logic [SEQ_W-1:0] cq_in_q, cq_in_d, cq_out_q, cq_out_d;
		bto_mst_t mst_q, mst_d;
		logic rr_q, rr_d, tv_q, tv_d, done_q, done_d, retry_q, retry_d, idle_q, idle_d;
		bto_txn_t tt_q, tt_d;
		logic [DATA_W-1:0] rd_q, rd_d;
		logic [SEQ_W-1:0] pw_cnt, dq_cnt, cq_cnt;
		bto_txn_t req, pw_head, dq_head, cq_head;
		logic take, pw_full, dq_full, cq_full, pw_av, dr_av, cpl_ok;

		assign req = bus.ini_txn[d];
		assign pw_cnt = pw_in_q - pw_out_q;
		assign dq_cnt = dq_in_q - dq_out_q;
		assign cq_cnt = cq_in_q - cq_out_q;
		assign pw_full = pw_cnt == SEQ_W'(PW_DEPTH);
		assign dq_full = dq_cnt == SEQ_W'(DQ_DEPTH);
		assign cq_full = cq_cnt == SEQ_W'(CQ_DEPTH);
		assign pw_head = pw_mem_q[pw_out_q[PW_AW-1:0]];
		assign dq_head = dq_mem_q[dq_out_q[DQ_AW-1:0]];
		assign cq_head = cq_mem_q[cq_out_q[CQ_AW-1:0]];
		// One request per answer; the cycle of a pulse is the agent's drop cycle
		assign take = bus.ini_valid[d] && !done_q && !retry_q;
		assign pw_av = pw_cnt != '0;
		// Read waits for posted writes queued ahead of it, and needs a completion slot
		assign dr_av = dq_cnt != '0 && !cq_full
			&& bto_seq_ok(dq_tag_q[dq_out_q[DQ_AW-1:0]], pw_out_q);
		// Read data pulls reverse-direction writes ahead; write status may pass them
		assign cpl_ok = cq_cnt != '0 && cq_head == req && (cq_head.cmd[0]
			|| bto_seq_ok(cq_tag_q[cq_out_q[CQ_AW-1:0]], g_dir[O].pw_out_q));

		always_comb begin
			logic known;
			logic [SEQ_W-1:0] ix;
			known = 1'b0;
			ix = '0;
			pw_mem_d = pw_mem_q;
			pw_in_d = pw_in_q;
			pw_out_d = pw_out_q;
			dq_mem_d = dq_mem_q;
			dq_tag_d = dq_tag_q;
			dq_in_d = dq_in_q;
			dq_out_d = dq_out_q;
			cq_mem_d = cq_mem_q;
			cq_rd_d = cq_rd_q;
			cq_tag_d = cq_tag_q;
			cq_in_d = cq_in_q;
			cq_out_d = cq_out_q;
			mst_d = mst_q;
			rr_d = rr_q;
			tv_d = tv_q;
			tt_d = tt_q;
			done_d = 1'b0;
			retry_d = 1'b0;
			rd_d = rd_q;
			// A repeat of a request already queued or already executed
			for (int i = 0; i < DQ_DEPTH; i++) begin
				ix = dq_out_q + SEQ_W'(i);
				if (SEQ_W'(i) < dq_cnt && dq_mem_q[ix[DQ_AW-1:0]] == req) known = 1'b1;
			end
			for (int i = 0; i < CQ_DEPTH; i++) begin
				ix = cq_out_q + SEQ_W'(i);
				if (SEQ_W'(i) < cq_cnt && cq_mem_q[ix[CQ_AW-1:0]] == req) known = 1'b1;
			end

			if (take) begin
				if (bto_is_posted(req.cmd)) begin
					// Only buffer space matters, never the delayed traffic
					if (!pw_full) begin
						pw_mem_d[pw_in_q[PW_AW-1:0]] = req;
						pw_in_d = pw_in_q + 1'b1;
						done_d = 1'b1;
					end else begin
						retry_d = 1'b1;
					end
				end else if (cpl_ok) begin
					done_d = 1'b1;
					rd_d = cq_rd_q[cq_out_q[CQ_AW-1:0]];
					cq_out_d = cq_out_q + 1'b1;
				end else begin
					retry_d = 1'b1;
					// Only completion heads finish, others retry meanwhile
					if (!known && !dq_full) begin
						dq_mem_d[dq_in_q[DQ_AW-1:0]] = req;
						dq_tag_d[dq_in_q[DQ_AW-1:0]] = pw_in_q;
						dq_in_d = dq_in_q + 1'b1;
					end
				end
			end

			case (mst_q)
				BTO_M_IDLE: begin
					// Low rr_q favours posted writes; set by a posted grant, cleared by a delayed one
					if (pw_av && (!dr_av || !rr_q)) begin
						mst_d = BTO_M_PW;
						tv_d = 1'b1;
						tt_d = pw_head;
						rr_d = 1'b1;
					end else if (dr_av) begin
						mst_d = BTO_M_DR;
						tv_d = 1'b1;
						tt_d = dq_head;
						rr_d = 1'b0;
					end
				end
				BTO_M_PW: begin
					if (bus.tgt_ack[d]) begin
						mst_d = BTO_M_IDLE;
						tv_d = 1'b0;
						pw_out_d = pw_out_q + 1'b1;
					end
				end
				BTO_M_DR: begin
					if (bus.tgt_ack[d]) begin
						mst_d = BTO_M_IDLE;
						tv_d = 1'b0;
						dq_out_d = dq_out_q + 1'b1;
						cq_mem_d[cq_in_q[CQ_AW-1:0]] = tt_q;
						cq_rd_d[cq_in_q[CQ_AW-1:0]] = bus.tgt_rdata[d];
						cq_tag_d[cq_in_q[CQ_AW-1:0]] = g_dir[O].pw_in_q;
						cq_in_d = cq_in_q + 1'b1;
					end
				end
				default: begin
					mst_d = BTO_M_IDLE;
					tv_d = 1'b0;
				end
			endcase
			idle_d = pw_in_d == pw_out_d && dq_in_d == dq_out_d && cq_in_d == cq_out_d && !tv_d;
		end

		always_ff @(posedge clk) begin
			pw_mem_q <= pw_mem_d;
			dq_mem_q <= dq_mem_d;
			dq_tag_q <= dq_tag_d;
			cq_mem_q <= cq_mem_d;
			cq_rd_q <= cq_rd_d;
			cq_tag_q <= cq_tag_d;
			tt_q <= tt_d;
			rd_q <= rd_d;
			if (rst) begin
				pw_in_q <= SEQ_RST;
				pw_out_q <= SEQ_RST;
				dq_in_q <= SEQ_RST;
				dq_out_q <= SEQ_RST;
				cq_in_q <= SEQ_RST;
				cq_out_q <= SEQ_RST;
				mst_q <= BTO_M_IDLE;
				rr_q <= RR_RST;
				tv_q <= 1'b0;
				done_q <= 1'b0;
				retry_q <= 1'b0;
				idle_q <= 1'b1;
			end else begin
				pw_in_q <= pw_in_d;
				pw_out_q <= pw_out_d;
				dq_in_q <= dq_in_d;
				dq_out_q <= dq_out_d;
				cq_in_q <= cq_in_d;
				cq_out_q <= cq_out_d;
				mst_q <= mst_d;
				rr_q <= rr_d;
				tv_q <= tv_d;
				done_q <= done_d;
				retry_q <= retry_d;
				idle_q <= idle_d;
			end
		end

		assign bus.ini_done[d] = done_q;
		assign bus.ini_retry[d] = retry_q;
		assign bus.ini_rdata[d] = rd_q;
		assign bus.tgt_valid[d] = tv_q;
		assign bus.tgt_txn[d] = tt_q;
		assign dir_idle[d] = idle_q;
	end
endmodule : bto_bridge

/* bto_checker.sv */
// Checker of the carrier between the bridge ordering engine and the bus agents.
// Assumes one clock domain and every carrier signal wired in by name.
`timescale 1ns/1ns
module bto_checker import bto_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic ini_valid [2],
	input bto_txn_t ini_txn [2],
	input wire logic ini_done [2],
	input wire logic ini_retry [2],
	input wire logic [DATA_W-1:0] ini_rdata [2],
	input wire logic tgt_valid [2],
	input bto_txn_t tgt_txn [2],
	input wire logic tgt_ack [2],
	input wire logic [DATA_W-1:0] tgt_rdata [2]
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	function automatic logic chk_posted(input logic [3:0] c);
		return c == CMD_MEM_WR || c == CMD_MEM_WRI;
	endfunction : chk_posted

	for (genvar d = 0; d < 2; d++) begin : g_dir
		// Executed delayed work not yet returned, and accepted posted writes not yet issued
		logic [7:0] np_q, np_d, pw_q, pw_d;
		always_comb begin
			np_d = np_q;
			pw_d = pw_q;
			if (tgt_valid[d] && tgt_ack[d]) begin
				if (chk_posted(tgt_txn[d].cmd)) pw_d = pw_d - 8'h01;
				else np_d = np_d + 8'h01;
			end
			if (ini_done[d]) begin
				if (chk_posted(ini_txn[d].cmd)) pw_d = pw_d + 8'h01;
				else np_d = np_d - 8'h01;
			end
		end
		always_ff @(posedge clk) begin
			np_q <= rst ? 8'h00 : np_d;
			pw_q <= rst ? 8'h00 : pw_d;
		end

		a_answer_next: assert property (ini_valid[d] && !ini_done[d] && !ini_retry[d]
			|=> ini_done[d] || ini_retry[d])
			else $error("request not answered next cycle");
		a_answer_excl: assert property (!(ini_done[d] && ini_retry[d]))
			else $error("done and retry together");
		a_pulse_once: assert property (ini_done[d] |=> !ini_done[d] && !ini_retry[d])
			else $error("answer longer than one cycle");
		a_retry_release: assert property (ini_retry[d] |=> !ini_valid[d])
			else $error("initiator kept request after retry");
		a_tgt_hold: assert property (tgt_valid[d] && !tgt_ack[d] |=> tgt_valid[d] && $stable(tgt_txn[d]))
			else $error("target request changed before ack");
		a_ack_timing: assert property ($rose(tgt_valid[d]) |=> tgt_ack[d])
			else $error("target ack late");
		a_grant_gap: assert property (tgt_valid[d] && tgt_ack[d] |=> !tgt_valid[d])
			else $error("no idle cycle between grants");
		a_delayed_exec: assert property (ini_done[d] && !chk_posted(ini_txn[d].cmd) |-> np_q != 8'h00)
			else $error("delayed request done before target execution");
		a_posted_known: assert property ($rose(tgt_valid[d]) && chk_posted(tgt_txn[d].cmd)
			|-> pw_q != 8'h00 || (ini_done[d] && chk_posted(ini_txn[d].cmd)))
			else $error("posted write issued without acceptance");
		c_retry: cover property (ini_retry[d]);
		c_posted: cover property (tgt_ack[d] && chk_posted(tgt_txn[d].cmd));
		c_read_done: cover property (ini_done[d] && !ini_txn[d].cmd[0]);
	end
endmodule : bto_checker

/* test_bridge_transaction_ordering.sv */
// Testbench: bridge ordering engine facing both bus agents through the carrier.
// Assumes package, carrier, both ends and checker are compiled before it.
`timescale 1ns/1ns
module test_bridge_transaction_ordering import bto_pkg::*;;
	logic clk;
	logic rst;
	logic [1:0] usr_valid;
	logic [1:0] usr_inorder;
	logic [1:0] usr_ready;
	logic [1:0] cpl_valid;
	logic [1:0] sync_ok;
	logic [1:0] dir_idle;
	bto_txn_t usr_txn [2];
	logic [DATA_W-1:0] cpl_rdata [2];
	logic [DATA_W-1:0] lrd [2];
	bto_txn_t tlog [2][$];
	int nretry [2];
	int ncpl [2];
	int opp_at_cpl [2];
	logic both_busy;
	int err_count;
	int checked;

	bto_if bto_if_inst ();
	bto_bridge bto_bridge_inst (.clk(clk), .rst(rst), .bus(bto_if_inst), .dir_idle(dir_idle));
	bto_agent bto_agent_inst (.clk(clk), .rst(rst), .bus(bto_if_inst), .usr_valid(usr_valid), .usr_txn(usr_txn),
		.usr_inorder(usr_inorder), .usr_ready(usr_ready), .cpl_valid(cpl_valid), .cpl_rdata(cpl_rdata),
		.sync_ok(sync_ok));
	bto_checker bto_checker_inst (.clk(clk), .rst(rst), .ini_valid(bto_if_inst.ini_valid),
		.ini_txn(bto_if_inst.ini_txn), .ini_done(bto_if_inst.ini_done), .ini_retry(bto_if_inst.ini_retry),
		.ini_rdata(bto_if_inst.ini_rdata), .tgt_valid(bto_if_inst.tgt_valid), .tgt_txn(bto_if_inst.tgt_txn),
		.tgt_ack(bto_if_inst.tgt_ack), .tgt_rdata(bto_if_inst.tgt_rdata));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Sampled mid-cycle so each one-cycle pulse is counted exactly once
	always @(negedge clk) begin
		for (int d = 0; d < 2; d++) begin
			if (bto_if_inst.tgt_valid[d] === 1'b1 && bto_if_inst.tgt_ack[d] === 1'b1) begin
				tlog[d].push_back(bto_if_inst.tgt_txn[d]);
			end
			if (bto_if_inst.ini_retry[d] === 1'b1) nretry[d]++;
			if (cpl_valid[d] === 1'b1) begin
				ncpl[d]++;
				lrd[d] = cpl_rdata[d];
				// Reverse-direction target transactions already finished when this answer came back
				opp_at_cpl[d] = tlog[1 - d].size();
			end
		end
		if (bto_if_inst.tgt_valid[0] === 1'b1 && bto_if_inst.tgt_valid[1] === 1'b1) both_busy = 1'b1;
	end

	task automatic report_and_stop();
		if (err_count == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : report_and_stop

	task automatic check(input logic [71:0] seen, input logic [71:0] exp, input string msg);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask : check

	task automatic tick(inout int n);
		@(negedge clk);
		n++;
		if (n > 3000) begin
			err_count++;
			$display("[FAIL] %0t wait timed out", $time);
			report_and_stop();
		end
	endtask : tick

	function automatic bto_txn_t mk(input logic [3:0] c, input logic [7:0] a, input logic [7:0] v, input logic [3:0] b);
		return '{cmd: c, addr: {24'h000000, a}, data: {4{v}}, be: b};
	endfunction : mk

	task automatic send(input int d, input bto_txn_t t);
		int n;
		n = 0;
		tick(n);
		while (usr_ready[d] !== 1'b1) tick(n);
		usr_txn[d] = t;
		usr_valid[d] = 1'b1;
		tick(n);
		usr_valid[d] = 1'b0;
	endtask : send

	task automatic settle(input int d, input int tgt);
		int n;
		n = 0;
		while (ncpl[d] < tgt || dir_idle !== 2'b11) tick(n);
	endtask : settle

	task automatic sc_cmd_classes();
		logic [3:0] cmds [7];
		bto_txn_t t;
		int r0;
		int c0;
		int d;
		cmds = '{CMD_IO_RD, CMD_IO_WR, CMD_MEM_RD, CMD_MEM_WR, CMD_CFG_RD, CMD_CFG_WR, CMD_MEM_WRI};
		for (int i = 0; i < 7; i++) begin
			d = i % 2;
			r0 = nretry[d];
			c0 = ncpl[d];
			t = mk(cmds[i], 8'h40 + 8'(i * 4), 8'(i), 4'hf);
			send(d, t);
			settle(d, c0 + 1);
			check(72'(nretry[d] != r0), 72'(cmds[i] != CMD_MEM_WR && cmds[i] != CMD_MEM_WRI), "retry class");
			check(tlog[d][$], t, "target txn");
		end
	endtask : sc_cmd_classes

	// Same address twice with different lanes: must stay two writes
	task automatic sc_posted_order();
		bto_txn_t w [3];
		int n0;
		int c0;
		w[0] = mk(CMD_MEM_WR, 8'h10, 8'h11, 4'h1);
		w[1] = mk(CMD_MEM_WR, 8'h10, 8'h22, 4'h2);
		w[2] = mk(CMD_MEM_WRI, 8'h14, 8'h33, 4'hf);
		n0 = tlog[0].size();
		c0 = ncpl[0];
		for (int i = 0; i < 3; i++) send(0, w[i]);
		settle(0, c0 + 3);
		check(72'(tlog[0].size()), 72'(n0 + 3), "write count");
		for (int i = 0; i < 3; i++) check(tlog[0][n0 + i], w[i], "write order");
	endtask : sc_posted_order

	task automatic sc_read_back();
		bto_txn_t w [3];
		int n0;
		int c0;
		usr_inorder = 2'b11;
		w[0] = mk(CMD_MEM_WR, 8'h20, 8'h5a, 4'hf);
		w[1] = mk(CMD_IO_WR, 8'h24, 8'h66, 4'hf);
		w[2] = mk(CMD_MEM_RD, 8'h20, 8'h00, 4'hf);
		n0 = tlog[1].size();
		c0 = ncpl[1];
		for (int i = 0; i < 3; i++) send(1, w[i]);
		settle(1, c0 + 3);
		for (int i = 0; i < 3; i++) check(tlog[1][n0 + i], w[i], "delayed passed write");
		check(72'(lrd[1]), 72'({4{8'h5a}}), "read back");
		check(72'(sync_ok[1]), 72'(1'b1), "sync after read");
		usr_inorder = 2'b00;
	endtask : sc_read_back

	task automatic sc_cross();
		int c0;
		int c1;
		int p1;
		both_busy = 1'b0;
		c0 = ncpl[0];
		c1 = ncpl[1];
		fork
			begin
				send(0, mk(CMD_MEM_WR, 8'h30, 8'h71, 4'hf));
				send(0, mk(CMD_MEM_WR, 8'h34, 8'h72, 4'hf));
			end
			begin
				send(1, mk(CMD_MEM_WR, 8'h30, 8'h81, 4'hf));
				send(1, mk(CMD_MEM_WR, 8'h34, 8'h82, 4'hf));
			end
		join
		settle(0, c0 + 2);
		settle(1, c1 + 2);
		check(72'(both_busy), 72'(1'b1), "no concurrent writes");
		p1 = tlog[1].size();
		send(1, mk(CMD_MEM_WR, 8'h38, 8'h91, 4'hf));
		send(0, mk(CMD_MEM_RD, 8'h3c, 8'h00, 4'hf));
		settle(0, c0 + 3);
		check(72'(opp_at_cpl[0] > p1), 72'(1'b1), "read data before write");
		settle(1, c1 + 3);
	endtask : sc_cross

	initial begin
		rst = 1'b1;
		usr_valid = 2'b00;
		usr_inorder = 2'b00;
		usr_txn[0] = '0;
		usr_txn[1] = '0;
		both_busy = 1'b0;
		err_count = 0;
		checked = 0;
		repeat (4) @(negedge clk);
		rst = 1'b0;
		sc_cmd_classes();
		sc_posted_order();
		sc_read_back();
		sc_cross();
		report_and_stop();
	end
endmodule : test_bridge_transaction_ordering
